// ==== sbc_cfg_status.sv ====
// Purpose: Configuration word, first status word and serial port of the basis chip.
// Assumes: Serial clock idles low; device changes data on rising, samples on falling edges.
// Notes:   Chip select must be low for three reference cycles before the first serial edge.
// Functional notes
// - Open-load threshold bit selects 2 or 8 mA
// - Unlatched: outputs recover after supply fault ends
// - Latched: high-side outputs stay off until status clear
// - Auxiliary driver recovery mode follows its bit
// - Pull-up disable bit removes bus pull-up
// - Time-out disable bit removes dominant time-out
// - Reset threshold code 00 high, 01 low
// - Wake filter code 00: static 64 us
// - Code 01: cyclic timer2, 80 us, 16 us
// - Codes 10/11: 800 us delay, timer2/timer1
// - Slope bit selects high or low slew
// - Low-side drivers off on supply fault unless disabled
// - Regulator current check enabled when bit set
// - Status word shifts out on output/config frames
// - Status word is 22 bits, resets zero
// - Open-load flags set on detected open load
// - Overcurrent flags set on detected overcurrent
// - Regulator2 short flag if low 4 ms after turn-on
// - Wake status shows filtered wake inputs
// - Wake source flags record enable-pin or bus wake
// - Power-on flag cleared by first access
// - Clear command empties status flags; filtered wake bits stay
`timescale 1ns/1ps
module sbc_cfg_status #(
  parameter int unsigned STATIC_CYC_P = sbc_pkg::STATIC_CYC,
  parameter int unsigned SHORT_CYC_P  = sbc_pkg::CYC_SHORT_CYC,
  parameter int unsigned LONG_CYC_P   = sbc_pkg::CYC_LONG_CYC,
  parameter int unsigned SHT_CYC_P    = sbc_pkg::SHT_CYC
) (
  // Reference clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  // Serial link from the host.
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_n,
  input  wire logic        spi_mosi,
  output logic             spi_miso,
  output logic             spi_miso_oe,
  // Monitors from the analog section, asynchronous levels.
  input  wire logic [4:0]  open_load_det,
  input  wire logic [6:0]  overcurrent_det,
  input  wire logic        regulator2_on,
  input  wire logic        regulator2_low,
  input  wire logic [3:0]  wake_pin,
  input  wire logic        enable_pin_wake_evt,
  input  wire logic        lin_wake_evt,
  input  wire logic        supply_overvoltage,
  input  wire logic        supply_undervoltage,
  input  wire logic        cyc_timer1_on,
  input  wire logic        cyc_timer2_on,
  // Configuration towards the drivers and regulators.
  output logic [3:0]       open_load_threshold_select,
  output logic             aux_driver_recovery,
  output logic             bus_pullup_disable,
  output logic             dominant_timeout_disable,
  output logic [1:0]       reset_threshold_select,
  output logic             bus_slope_select,
  output logic             regulator_current_check,
  // Output gating after supply faults.
  output logic             hs_outputs_enable,
  output logic             low_side_enable
);
  import sbc_pkg::*;

  // Refuse counts that the 20-bit timers cannot hold.
  initial begin
    if (STATIC_CYC_P < 2 || SHORT_CYC_P < 2 || LONG_CYC_P < 2 || SHT_CYC_P < 2 ||
        STATIC_CYC_P >= 2**TMR_W || LONG_CYC_P >= 2**TMR_W || SHT_CYC_P >= 2**TMR_W ||
        SHORT_CYC_P >= 2**TMR_W) begin
      $error("sbc_cfg_status: timer count out of range");
    end
  end

  localparam logic [TMR_W-1:0] STATIC_M1 = TMR_W'(STATIC_CYC_P - 1);
  localparam logic [TMR_W-1:0] SHORT_M1  = TMR_W'(SHORT_CYC_P - 1);
  localparam logic [TMR_W-1:0] LONG_M1   = TMR_W'(LONG_CYC_P - 1);
  localparam logic [TMR_W-1:0] FILT_M1   = TMR_W'(FILT_CYC - 1);
  localparam logic [TMR_W-1:0] SHT_M1    = TMR_W'(SHT_CYC_P - 1);
  localparam logic [CNT_W-1:0] LAST_BIT  = CNT_W'(FRAME_BITS - 1);
  localparam logic [CNT_W-1:0] FULL_CNT  = CNT_W'(FRAME_BITS);
  localparam logic [CNT_W-1:0] ADDR_CNT  = CNT_W'(ADDR_BITS);

  // ---------------- Link domain ----------------
  logic                  link_rst_n;  // Held in reset while the frame is inactive.
  logic [CNT_W-1:0]      rx_cnt_q;    // Falling edges seen in this frame.
  logic [FRAME_BITS-1:0] rx_sh_q;     // Incoming shift register.
  logic [FRAME_BITS-1:0] frame_word_q; // Last complete frame, stable until the next ends.
  logic                  frame_tog_q; // Toggles once per complete frame.
  logic [CNT_W-1:0]      tx_cnt_q;    // Rising edges seen in this frame.
  logic [WORD_BITS-1:0]  tx_sh_q;     // Outgoing shift register.
  logic [WORD_BITS-1:0]  shadow_q;    // Status snapshot, frozen while chip select is low.
  logic                  implicit_rd; // Frame addresses a word that returns the status.

  assign link_rst_n  = arst_n & ~spi_cs_n;
  assign implicit_rd = (rx_sh_q[1:0] == ADDR_OUTPUT_CTRL) || (rx_sh_q[1:0] == ADDR_CFG_CTRL);

  // Sample the host data on falling edges; the counter saturates at a full frame.
  always_ff @(negedge spi_sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rx_cnt_q <= '0;
      rx_sh_q  <= '0;
    end else begin
      rx_sh_q <= {rx_sh_q[FRAME_BITS-2:0], spi_mosi};
      if (rx_cnt_q != FULL_CNT) begin
        rx_cnt_q <= rx_cnt_q + 5'h01;
      end
    end
  end

  // Hold each complete frame and announce it by a toggle; short frames are dropped.
  always_ff @(negedge spi_sclk or negedge arst_n) begin
    if (!arst_n) begin
      frame_word_q <= '0;
      frame_tog_q  <= 1'b0;
    end else if (!spi_cs_n && rx_cnt_q == LAST_BIT) begin
      frame_word_q <= {rx_sh_q[FRAME_BITS-2:0], spi_mosi};
      frame_tog_q  <= ~frame_tog_q;
    end
  end

  // Drive the answer on rising edges: two zero bits, then the status or zeros.
  always_ff @(posedge spi_sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_cnt_q    <= '0;
      tx_sh_q     <= '0;
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      spi_miso_oe <= 1'b1;
      if (tx_cnt_q != FULL_CNT) begin
        tx_cnt_q <= tx_cnt_q + 5'h01;
      end
      if (tx_cnt_q < ADDR_CNT) begin
        spi_miso <= 1'b0;
      end else if (tx_cnt_q == ADDR_CNT) begin
        // The address is complete here; the shadow is quiet during the frame.
        spi_miso <= implicit_rd ? shadow_q[WORD_BITS-1] : 1'b0;
        tx_sh_q  <= implicit_rd ? {shadow_q[WORD_BITS-2:0], 1'b0} : '0;
      end else begin
        spi_miso <= tx_sh_q[WORD_BITS-1];
        tx_sh_q  <= {tx_sh_q[WORD_BITS-2:0], 1'b0};
      end
    end
  end

  // ---------------- Reference domain ----------------
  localparam int unsigned NSYNC = 25;
  logic [NSYNC-1:0] async_in;   // All pins that enter from outside this domain.
  logic [NSYNC-1:0] sync1_q;    // First synchroniser stage, read only by the second.
  logic [NSYNC-1:0] sync2_q;    // Second stage, safe to use.
  logic [2:0]       ft_q;       // Frame toggle synchroniser plus one delay stage.
  logic             frame_pulse; // One cycle per received frame.
  logic [1:0]       fr_addr;    // Address of the received frame.
  logic [21:0]      fr_data;    // Data of the received frame.
  logic             clr_cmd;    // Status clear requested.
  logic [21:0]      cfg_q;      // Configuration word.
  logic [4:0]       ol_q;       // Open-load flags.
  logic [6:0]       oc_q;       // Overcurrent flags.
  logic             sht_q;      // Regulator2 short flag.
  logic [TMR_W-1:0] sht_cnt_q;  // Time since regulator2 turn-on.
  logic [3:0]       wf_q;       // Filtered wake inputs.
  logic             en_wake_q;  // Enable-pin wake flag.
  logic             lin_wake_q; // Bus wake flag.
  logic [1:0]       wake_prev_q; // Previous wake event levels for edge detect.
  logic             por_pend_q; // Marks the first cycle after reset release.
  logic             por_q;      // Power-on flag.
  logic             sv_flag_q;  // Sticky supply fault for the high-side lockout; not in the status word.
  logic [21:0]      status_d;   // Assembled status word.

  assign async_in = {open_load_det, overcurrent_det, regulator2_on, regulator2_low, wake_pin,
                     enable_pin_wake_evt, lin_wake_evt, supply_overvoltage, supply_undervoltage,
                     cyc_timer1_on, cyc_timer2_on, spi_cs_n};
  wire [4:0] s_ol     = sync2_q[24:20];
  wire [6:0] s_oc     = sync2_q[19:13];
  wire       s_v2_on  = sync2_q[12];
  wire       s_v2_low = sync2_q[11];
  wire [3:0] s_wake   = sync2_q[10:7];
  wire       s_en_evt = sync2_q[6];
  wire       s_lin_evt = sync2_q[5];
  wire       s_sv_now = sync2_q[4] | sync2_q[3];
  wire       s_t1     = sync2_q[2];
  wire       s_t2     = sync2_q[1];
  wire       s_cs_n   = sync2_q[0];

  // Two-stage synchronisers for every pin and for the frame toggle.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      ft_q    <= '0;
    end else begin
      sync1_q <= async_in;
      sync2_q <= sync1_q;
      ft_q    <= {ft_q[1:0], frame_tog_q};
    end
  end

  assign frame_pulse = ft_q[2] ^ ft_q[1];
  assign fr_addr     = frame_word_q[FRAME_BITS-1:WORD_BITS];
  assign fr_data     = frame_word_q[WORD_BITS-1:0];
  assign clr_cmd     = frame_pulse && fr_addr == ADDR_SUPPLY_CTRL && fr_data[CLR_BIT];

  // Configuration word; the reserved threshold codes are stored as the host wrote them.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_q <= CFG_RESET;
    end else if (frame_pulse && fr_addr == ADDR_CFG_CTRL) begin
      cfg_q <= fr_data;
    end
  end

  assign open_load_threshold_select = cfg_q[F_OLT_LSB +: 4];
  assign aux_driver_recovery        = cfg_q[F_AUX_REC];
  assign bus_pullup_disable         = cfg_q[F_PU_DIS];
  assign dominant_timeout_disable   = cfg_q[F_TOUT_DIS];
  assign reset_threshold_select     = cfg_q[F_RST_LSB +: 2];
  assign bus_slope_select           = cfg_q[F_SLOPE];
  assign regulator_current_check    = cfg_q[F_CUR_CHK];

  // Event flags: a new detection wins over a clear in the same cycle.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      ol_q        <= '0;
      oc_q        <= '0;
      en_wake_q   <= 1'b0;
      lin_wake_q  <= 1'b0;
      wake_prev_q <= '0;
      sv_flag_q   <= 1'b0;
    end else begin
      ol_q        <= (ol_q & ~{5{clr_cmd}}) | s_ol;
      oc_q        <= (oc_q & ~{7{clr_cmd}}) | s_oc;
      wake_prev_q <= {s_en_evt, s_lin_evt};
      en_wake_q   <= (en_wake_q & ~clr_cmd) | (s_en_evt & ~wake_prev_q[1]);
      lin_wake_q  <= (lin_wake_q & ~clr_cmd) | (s_lin_evt & ~wake_prev_q[0]);
      sv_flag_q   <= (sv_flag_q & ~clr_cmd) | s_sv_now;
    end
  end

  // Power-on flag: set just after reset release, cleared by the first frame or a clear.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      por_pend_q <= 1'b1;
      por_q      <= 1'b0;
    end else begin
      por_pend_q <= 1'b0;
      por_q      <= (por_q & ~(frame_pulse | clr_cmd)) | por_pend_q;
    end
  end

  // Regulator2 short check at the fixed time after turn-on.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      sht_cnt_q <= '0;
      sht_q     <= 1'b0;
    end else begin
      if (!s_v2_on) begin
        sht_cnt_q <= '0;
      end else if (sht_cnt_q != SHT_M1 + 20'h00001) begin
        sht_cnt_q <= sht_cnt_q + 20'h00001;
      end
      sht_q <= (sht_q & ~clr_cmd) | (s_v2_on && sht_cnt_q == SHT_M1 && s_v2_low);
    end
  end

  // One wake filter per input; the mode comes from its two configuration bits.
  for (genvar i = 0; i < 4; i++) begin : g_wake
    sbc_wf_state_t    st_q;     // Sequencer state.
    logic [TMR_W-1:0] cnt_q;    // Delay or stability count.
    logic             raw_q;    // Input level one cycle ago.
    logic             on_q;     // Timer window one cycle ago.
    logic [1:0]       code;
    logic             tmr_on;
    logic [TMR_W-1:0] dly_m1;
    logic [TMR_W-1:0] flt_m1;
    assign code   = cfg_q[F_WF_LSB + 2*i +: 2];
    assign tmr_on = (code == 2'b11) ? s_t1 : s_t2;
    assign dly_m1 = (code == 2'b01) ? SHORT_M1 : LONG_M1;
    assign flt_m1 = (code == 2'b00) ? STATIC_M1 : FILT_M1;

    // Static mode filters all the time; cyclic modes filter inside each timer window.
    always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
        st_q    <= WF_IDLE;
        cnt_q   <= '0;
        raw_q   <= 1'b0;
        on_q    <= 1'b0;
        wf_q[i] <= 1'b0;
      end else begin
        raw_q <= s_wake[i];
        on_q  <= tmr_on;
        unique case (st_q)
          WF_IDLE: begin
            cnt_q <= '0;
            if (code == 2'b00 || (tmr_on && !on_q)) begin
              st_q <= (code == 2'b00) ? WF_FILT : WF_DELAY;
            end
          end
          WF_DELAY: begin
            if (code == 2'b00 || !tmr_on) begin
              st_q <= WF_IDLE;
            end else if (cnt_q >= dly_m1) begin
              st_q  <= WF_FILT;
              cnt_q <= '0;
            end else begin
              cnt_q <= cnt_q + 20'h00001;
            end
          end
          WF_FILT: begin
            if (code != 2'b00 && !tmr_on) begin
              st_q <= WF_IDLE;
            end else if (s_wake[i] != raw_q) begin
              cnt_q <= '0;
            end else if (cnt_q >= flt_m1) begin
              wf_q[i] <= s_wake[i];
              if (code != 2'b00) begin
                st_q <= WF_IDLE;
              end
            end else begin
              cnt_q <= cnt_q + 20'h00001;
            end
          end
          default: begin
            st_q <= WF_IDLE;
          end
        endcase
      end
    end
  end

  assign status_d = {2'b00, por_q, lin_wake_q, en_wake_q, wf_q, sht_q, oc_q, ol_q};

  // Status snapshot follows the flags only while no frame is in progress.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      shadow_q <= STATUS_RESET;
    end else if (s_cs_n) begin
      shadow_q <= status_d;
    end
  end

  // Output gating after supply over- or undervoltage.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      hs_outputs_enable <= 1'b0;
      low_side_enable   <= 1'b0;
    end else begin
      hs_outputs_enable <= !(s_sv_now || (cfg_q[F_LATCH] && sv_flag_q));
      low_side_enable   <= !(s_sv_now && !cfg_q[F_RELAY_DIS]);
    end
  end

  AST_OLT_WRITE: assert property (@(posedge ref_clk) disable iff (!arst_n)
    frame_pulse && fr_addr == ADDR_CFG_CTRL |=> open_load_threshold_select == $past(fr_data[3:0]))
    else $error("threshold select not loaded");
  AST_AUTO_RECOVER: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !cfg_q[F_LATCH] && !s_sv_now |=> hs_outputs_enable) else $error("outputs did not recover");
  AST_LOCKOUT: assert property (@(posedge ref_clk) disable iff (!arst_n)
    cfg_q[F_LATCH] && sv_flag_q && !clr_cmd |=> !hs_outputs_enable ##1 !hs_outputs_enable)
    else $error("lockout released early");
  AST_LS_OFF: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_sv_now && !cfg_q[F_RELAY_DIS] |=> !low_side_enable) else $error("low side not off");
  AST_OL_HOLD: assert property (@(posedge ref_clk) disable iff (!arst_n)
    ol_q[0] && !clr_cmd |=> ol_q[0]) else $error("open-load flag lost");
  AST_OC_SET: assert property (@(posedge ref_clk) disable iff (!arst_n)
    $rose(s_oc[0]) |=> oc_q[0]) else $error("overcurrent not flagged");
  AST_CLR: assert property (@(posedge ref_clk) disable iff (!arst_n)
    clr_cmd && !s_oc[1] |=> !oc_q[1]) else $error("clear did not empty flag");
  AST_POR_CLR: assert property (@(posedge ref_clk) disable iff (!arst_n)
    frame_pulse && !por_pend_q |=> !por_q) else $error("power-on flag not cleared");
  AST_SHADOW: assert property (@(posedge ref_clk) disable iff (!arst_n)
    !s_cs_n ##1 !s_cs_n |-> $stable(shadow_q)) else $error("snapshot moved in frame");
  AST_SHT: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_v2_on && sht_cnt_q == SHT_M1 && s_v2_low |=> sht_q) else $error("short not flagged");
  AST_LIN_WAKE: assert property (@(posedge ref_clk) disable iff (!arst_n)
    s_lin_evt && !wake_prev_q[0] |=> lin_wake_q [*2]) else $error("bus wake not held");
  COV_CFG: cover property (@(posedge ref_clk) disable iff (!arst_n) frame_pulse && fr_addr == ADDR_CFG_CTRL);
  COV_CLR: cover property (@(posedge ref_clk) disable iff (!arst_n) clr_cmd && sv_flag_q);
  COV_LOCK: cover property (@(posedge ref_clk) disable iff (!arst_n)
    cfg_q[F_LATCH] && sv_flag_q && !s_sv_now);
endmodule : sbc_cfg_status

// ==== sbc_pkg.sv ====
// Purpose: Shared constants for the configuration and fault-status bank.
// Assumes: 24-bit serial frames, two address bits first, then 22 data bits, MSB first.
// Notes:   Cycle counts are derived from times in ns and the 250 MHz reference clock.
package sbc_pkg;
  // Frame layout.
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned ADDR_BITS  = 2;
  localparam int unsigned WORD_BITS  = 22;
  localparam int unsigned CNT_W      = 5;
  // Control word addresses.
  localparam logic [1:0] ADDR_OUTPUT_CTRL = 2'h0;
  localparam logic [1:0] ADDR_SUPPLY_CTRL = 2'h1;
  localparam logic [1:0] ADDR_CFG_CTRL    = 2'h2;
  localparam int unsigned CLR_BIT         = 21;
  // Configuration word field positions.
  localparam int unsigned F_OLT_LSB   = 0;
  localparam int unsigned F_LATCH     = 4;
  localparam int unsigned F_AUX_REC   = 5;
  localparam int unsigned F_PU_DIS    = 6;
  localparam int unsigned F_TOUT_DIS  = 7;
  localparam int unsigned F_RST_LSB   = 8;
  localparam int unsigned F_WF_LSB    = 10;
  localparam int unsigned F_SLOPE     = 18;
  localparam int unsigned F_RELAY_DIS = 19;
  localparam int unsigned F_CUR_CHK   = 20;
  localparam logic [21:0] CFG_RESET   = 22'h000000;
  // Status word field positions.
  localparam int unsigned S_OL_LSB    = 0;
  localparam int unsigned S_OC_LSB    = 5;
  localparam int unsigned S_SHT       = 12;
  localparam int unsigned S_WU_LSB    = 13;
  localparam int unsigned S_EN_WAKE   = 17;
  localparam int unsigned S_LIN_WAKE  = 18;
  localparam int unsigned S_POR       = 19;
  localparam logic [21:0] STATUS_RESET = 22'h000000;
  // Timing, in ns, and the clock rate.
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned T_STATIC_NS    = 64000;
  localparam int unsigned T_CYC_SHORT_NS = 80000;
  localparam int unsigned T_CYC_LONG_NS  = 800000;
  localparam int unsigned T_FILT_NS      = 16000;
  localparam int unsigned T_SHT_NS       = 4000000;
  localparam int unsigned STATIC_CYC     = T_STATIC_NS * CLK_MHZ / 1000;
  localparam int unsigned CYC_SHORT_CYC  = T_CYC_SHORT_NS * CLK_MHZ / 1000;
  localparam int unsigned CYC_LONG_CYC   = T_CYC_LONG_NS * CLK_MHZ / 1000;
  localparam int unsigned FILT_CYC       = T_FILT_NS * CLK_MHZ / 1000;
  localparam int unsigned SHT_CYC        = T_SHT_NS / 1000 * CLK_MHZ;
  localparam int unsigned TMR_W          = 20;
  // Wake filter sequencer states.
  typedef enum logic [1:0] {
    WF_IDLE  = 2'b00,
    WF_DELAY = 2'b01,
    WF_FILT  = 2'b10
  } sbc_wf_state_t;
endpackage : sbc_pkg

// ==== sbc_host.sv ====
// Purpose: Host model that masters the serial link of the bank.
// Assumes: Clock idles low; host changes data after falling edges and samples on them.
// Notes:   Between frames the data line shows the inverse of its last bit.
`timescale 1ns/1ps
module sbc_host (
  // Serial link towards the device.
  output logic      spi_sclk,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  // Idle link: clock low, select high.
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end

  // Sends address and data as one whole frame and returns the answer bits.
  task automatic frame(input logic [1:0] adr, input logic [21:0] dat, output logic [23:0] rx);
    logic [23:0] tx;
    tx = {adr, dat};
    spi_cs_n = 1'b0;
    spi_mosi = tx[23];
    // Select leads the first edge by more than three reference cycles.
    #15;
    for (int i = 23; i >= 0; i--) begin
      spi_sclk = 1'b1;
      #7.5;
      spi_sclk = 1'b0;
      rx[i] = spi_miso;
      #7.5;
      // Next bit goes out only after the device has sampled this one.
      if (i > 0) spi_mosi = tx[i-1];
    end
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    // Gap between frames, well above the minimum.
    #30;
  endtask : frame
endmodule : sbc_host

// ==== tb_sbc_cfg_status.sv ====
// Purpose: Self-checking bench for the configuration and fault-status bank.
// Assumes: Long counts except the 16 us filter shortened through the design parameters.
// Notes:   Link traffic comes from the host model; monitor inputs are driven here.
`timescale 1ns/1ps
module tb_sbc_cfg_status;
  import sbc_pkg::*;
  logic        ref_clk = 1'b0;
  logic        arst_n, spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
  logic [4:0]  open_load_det;
  logic [6:0]  overcurrent_det;
  logic [3:0]  wake_pin, open_load_threshold_select;
  logic [1:0]  reset_threshold_select;
  logic        regulator2_on, regulator2_low, enable_pin_wake_evt, lin_wake_evt;
  logic        supply_overvoltage, supply_undervoltage, cyc_timer1_on, cyc_timer2_on;
  logic        aux_driver_recovery, bus_pullup_disable, dominant_timeout_disable;
  logic        bus_slope_select, regulator_current_check, hs_outputs_enable, low_side_enable;
  logic [23:0] rx;
  int          errors = 0;
  int          tests_run = 0;
  // Configuration outputs gathered in field order.
  wire logic [10:0] cfg_o = {regulator_current_check, bus_slope_select, reset_threshold_select,
    dominant_timeout_disable, bus_pullup_disable, aux_driver_recovery, open_load_threshold_select};
  // Link idle state and output gating.
  wire logic [10:0] gate_o = {7'h0, spi_miso_oe, spi_miso, hs_outputs_enable, low_side_enable};
  // Rows: word written, outputs expected; the upper threshold bit is set only by the second row.
  logic [32:0] rows [6] = '{{22'h000000, 11'h000}, {22'h00000f, 11'h00f}, {22'h0000a5, 11'h055},
    {22'h000100, 11'h080}, {22'h140040, 11'h620}, {22'h080010, 11'h000}};

  always #2 ref_clk = ~ref_clk;

  sbc_host host (.spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso);
  sbc_cfg_status #(.STATIC_CYC_P(20), .SHORT_CYC_P(10), .LONG_CYC_P(30), .SHT_CYC_P(50)) DUT (
    .ref_clk, .arst_n, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .spi_miso_oe, .open_load_det,
    .overcurrent_det, .regulator2_on, .regulator2_low, .wake_pin, .enable_pin_wake_evt,
    .lin_wake_evt, .supply_overvoltage, .supply_undervoltage, .cyc_timer1_on, .cyc_timer2_on,
    .open_load_threshold_select, .aux_driver_recovery, .bus_pullup_disable,
    .dominant_timeout_disable, .reset_threshold_select, .bus_slope_select,
    .regulator_current_check, .hs_outputs_enable, .low_side_enable);

  // Waits n edges, then steps just past the edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc

  // Compares one frame answer.
  task automatic chk_word(input logic [23:0] got, input logic [23:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected answer at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  // Compares a group of output pins.
  task automatic chk_pins(input logic [10:0] got, input logic [10:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("unexpected pins at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_pins

  // Runs one frame, lets its effect land, and compares the answer.
  task automatic xfer(input logic [1:0] adr, input logic [21:0] dat, input logic [23:0] exp);
    host.frame(adr, dat, rx);
    cyc(8);
    chk_word(rx, exp);
  endtask : xfer

  // Prints the counts and the verdict, then ends the run.
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish

  // A hung run counts as a mismatch.
  initial begin
    #300000;
    errors++;
    tally_and_finish();
  end

  initial begin
    {open_load_det, overcurrent_det, wake_pin, regulator2_on, regulator2_low, enable_pin_wake_evt,
     lin_wake_evt, supply_overvoltage, supply_undervoltage, cyc_timer1_on, cyc_timer2_on, arst_n} = '0;
    cyc(12);
    arst_n = 1'b1;
    cyc(8);
    chk_pins(gate_o, 11'h003);
    xfer(2'h0, 22'h0, 24'h080000);
    xfer(2'h0, 22'h0, 24'h000000);
    foreach (rows[i]) begin
      xfer(2'h2, rows[i][32:11], 24'h0);
      chk_pins(cfg_o, rows[i][10:0]);
    end
    // Latched lockout, with the low-side shutdown disabled by the last row.
    supply_overvoltage = 1'b1;
    cyc(8);
    chk_pins(gate_o, 11'h001);
    supply_overvoltage = 1'b0;
    cyc(8);
    chk_pins(gate_o, 11'h001);
    xfer(2'h1, 22'h200000, 24'h0);
    chk_pins(gate_o, 11'h003);
    // Unlatched recovery and low-side shutdown.
    xfer(2'h2, 22'h0, 24'h0);
    supply_undervoltage = 1'b1;
    cyc(8);
    chk_pins(gate_o, 11'h000);
    supply_undervoltage = 1'b0;
    cyc(8);
    chk_pins(gate_o, 11'h003);
    // Short event pulses, a regulator short and steady wake levels.
    {open_load_det, overcurrent_det, enable_pin_wake_evt, lin_wake_evt} = {5'h15, 7'h6a, 2'b11};
    {regulator2_on, regulator2_low, wake_pin} = {2'b11, 4'h5};
    cyc(4);
    {open_load_det, overcurrent_det, enable_pin_wake_evt, lin_wake_evt} = '0;
    cyc(70);
    xfer(2'h2, 22'h0, 24'h06bd55);
    // Unused address stores nothing and answers zero.
    xfer(2'h3, 22'h3fffff, 24'h0);
    chk_pins(cfg_o, 11'h000);
    {regulator2_on, regulator2_low, wake_pin} = '0;
    cyc(40);
    xfer(2'h1, 22'h200000, 24'h0);
    xfer(2'h0, 22'h0, 24'h0);
    // Cyclic wake sensing: timer2 with the short delay, then timer1 with the long delay.
    xfer(2'h2, 22'h000400, 24'h0);
    {wake_pin, cyc_timer2_on} = {4'h1, 1'b1};
    cyc(4100);
    xfer(2'h2, 22'h000c00, 24'h002000);
    {wake_pin, cyc_timer2_on, cyc_timer1_on} = {4'h0, 2'b01};
    cyc(4100);
    xfer(2'h2, 22'h0, 24'h0);
    cyc_timer1_on = 1'b0;
    // Reset in mid-run returns everything to its reset state.
    arst_n = 1'b0;
    cyc(3);
    chk_pins(gate_o, 11'h000);
    arst_n = 1'b1;
    cyc(8);
    xfer(2'h0, 22'h0, 24'h080000);
    tally_and_finish();
  end
endmodule : tb_sbc_cfg_status
